// [include/fetch_decode_pkg.sv]
// shared types, opcodes and constants of the short-instruction fetch decoder
package fetch_decode_pkg;

	// ==========================================================
	// parcel buffer
	localparam logic [1:0] PARCEL_NONE = 2'h0;
	localparam logic [1:0] PARCEL_ONE = 2'h1;
	localparam logic [1:0] PARCEL_TWO = 2'h2;
	localparam int WORD_SHIFT = 2;
	localparam int HALF_SHIFT = 1;

	// ==========================================================
	// fixed register numbers
	localparam logic [4:0] REG_ZERO = 5'h00;
	localparam logic [4:0] REG_S0 = 5'h10;
	localparam logic [4:0] REG_S1 = 5'h11;
	localparam logic [4:0] REG_SP = 5'h1D;
	localparam logic [4:0] REG_RA = 5'h1F;

	// ==========================================================
	// major opcodes of the short forms
	localparam logic [5:0] MAJ_POOL_ARITH = 6'h01;
	localparam logic [5:0] MAJ_MOVE = 6'h03;
	localparam logic [5:0] MAJ_POOL_CTRL = 6'h11;
	localparam logic [5:0] MAJ_LOAD_SP = 6'h12;
	localparam logic [5:0] MAJ_POOL_ADDI = 6'h13;
	localparam logic [5:0] MAJ_POOL_ADDR = 6'h1B;
	localparam logic [5:0] MAJ_STORE_BYTE = 6'h22;
	localparam logic [5:0] MAJ_BRANCH_ZERO = 6'h23;
	localparam logic [5:0] MAJ_STORE_HALF = 6'h2A;
	localparam logic [5:0] MAJ_BRANCH_NZ = 6'h2B;
	localparam logic [5:0] MAJ_STORE_SP = 6'h32;
	localparam logic [5:0] MAJ_BRANCH = 6'h33;
	localparam logic [5:0] MAJ_NEGATE = 6'h39;
	localparam logic [5:0] MAJ_STORE_WORD = 6'h3A;

	// ==========================================================
	// minor opcodes
	localparam logic MINOR_ADDI_SAME = 1'h0;
	localparam logic MINOR_ADDI_TWO = 1'h0;
	localparam logic MINOR_SUB = 1'h1;
	localparam logic [5:0] MINOR_BREAK = 6'h2C;
	localparam logic [5:0] MINOR_DEBUG = 6'h3B;
	localparam logic [4:0] MINOR_JR = 5'h0C;
	localparam logic [4:0] MINOR_JRC = 5'h0D;
	localparam logic [4:0] MINOR_JALR = 5'h0E;
	localparam logic [4:0] MINOR_JALRS = 5'h0F;
	localparam logic [4:0] MINOR_RET_ADJ = 5'h18;

	// ==========================================================
	// decoded instruction
	typedef enum logic [4:0] {
		op_other, op_long, op_nop, op_move, op_add_imm, op_add, op_sub,
		op_load_word, op_store_byte, op_store_half, op_store_word,
		op_branch, op_branch_zero, op_branch_nonzero, op_jump_reg,
		op_jump_link_reg, op_return_adjust, op_break, op_debug_break
	} op_t;

	typedef enum logic [1:0] {slot_none, slot_any, slot_short, slot_long} slot_t;

	typedef struct packed {
		logic valid;
		logic is_long;
		logic [31:0] instr;
		op_t op;
		logic [4:0] rd;
		logic [4:0] rs;
		logic [4:0] rt;
		logic wr_en;
		logic [31:0] imm;
		slot_t slot;
		logic brk;
		logic dbg;
		logic [3:0] code;
	} dec_t;

	typedef struct packed {
		logic end_s1;
		logic end_s2;
		logic [2:0][15:0] parcel;
		logic [1:0] cnt;
		logic rdy;
		dec_t dec;
	} fe_state_t;

	// length comes from the major opcode alone
	function automatic logic is_short(input logic [5:0] major);
		case (major)
			MAJ_POOL_ARITH, MAJ_MOVE, MAJ_POOL_CTRL, MAJ_LOAD_SP, MAJ_POOL_ADDI,
			MAJ_POOL_ADDR, MAJ_STORE_BYTE, MAJ_BRANCH_ZERO, MAJ_STORE_HALF,
			MAJ_BRANCH_NZ, MAJ_STORE_SP, MAJ_BRANCH, MAJ_NEGATE,
			MAJ_STORE_WORD: is_short = 1'b1;
			default: is_short = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] two_reg_imm(input logic [2:0] code);
		case (code)
			3'h0: two_reg_imm = 32'hFFFFFFFF;
			3'h1: two_reg_imm = 32'h00000001;
			3'h2: two_reg_imm = 32'h00000004;
			3'h3: two_reg_imm = 32'h00000008;
			3'h4: two_reg_imm = 32'h0000000C;
			3'h5: two_reg_imm = 32'h00000010;
			3'h6: two_reg_imm = 32'h00000014;
			default: two_reg_imm = 32'h00000018;
		endcase
	endfunction

endpackage

// [core/parcel_order.sv]
// splits a fetched word into first and second parcel by endianness
`timescale 1ns/1ps
module parcel_order (
	input wire logic [31:0] i_word, // fetched memory word
	input wire logic i_big_endian, // high for big-endian order
	output logic [15:0] o_first, // lower-addressed parcel
	output logic [15:0] o_second // higher-addressed parcel
);
	always_comb begin
		if (i_big_endian) begin
			o_first = i_word[31:16];
			o_second = i_word[15:0];
		end else begin
			o_first = i_word[15:0];
			o_second = i_word[31:16];
		end
	end
endmodule

// [core/short_reg_map.sv]
// maps a 3-bit short register code to a general register number
`timescale 1ns/1ps
module short_reg_map (
	input wire logic [2:0] i_code, // 3-bit register code
	input wire logic i_store_src, // high for store source set
	output logic [4:0] o_reg // general register number
);
	always_comb begin
		case (i_code)
			3'h0: o_reg = i_store_src ? fetch_decode_pkg::REG_ZERO
				: fetch_decode_pkg::REG_S0;
			3'h1: o_reg = fetch_decode_pkg::REG_S1;
			default: o_reg = {2'h0, i_code};
		endcase
	end
endmodule

// [core/short_fetch_decoder.sv]
// fetch parcel buffer and short/long instruction decoder
// How it works
// - big-endian: first parcel bits 31..16
// - little-endian: first parcel bits 15..0
// - long instruction built from two parcels
// - earlier parcel forms upper half
// - parcels consumed in ascending address order
// - five-bit register fields decode linearly
// - move takes two unrestricted register fields
// - stack load/store offset scaled by four
// - four add-immediate forms decoded
// - move r0,r0 is no-op, no effect
// - negate is subtract from register zero
// - short branch offset scaled by two
// - breakpoints carry code, six-bit minor
// - two link-jump forms, long/short slot
// - compact jump has no delay slot
// - zero branches: 3-bit register, 7-bit offset
// - return-adjust: immediate, no register field
// - add-immediate widths 4, 9, 3, 6
// - short register width per instruction
// - length from first parcel major opcode
// - major opcode sits in top bits
// - short codes 0,1 select 16,17
// - store source code 0 selects zero
`timescale 1ns/1ps
module short_fetch_decoder (
	input wire logic i_ref_clk, // core clock
	input wire logic i_rstn, // synchronous reset, active low
	input wire logic i_ce, // clock enable, freezes all state
	input wire logic i_big_endian, // endianness pin, asynchronous
	input wire logic i_flush, // drop buffered parcels and output
	input wire logic i_fetch_valid, // fetched word offered
	input wire logic [31:0] i_fetch_word, // fetched aligned word
	output logic o_fetch_ready, // buffer can take a word
	input wire logic i_dec_ready, // consumer takes o_dec
	output fetch_decode_pkg::dec_t o_dec // decoded instruction
);
	// ==========================================================
	// state
	fetch_decode_pkg::fe_state_t s_reg;
	fetch_decode_pkg::fe_state_t s_next;
	logic [15:0] first_parcel;
	logic [15:0] second_parcel;
	logic [15:0] head;
	logic short_head;
	logic take;
	logic emit;
	logic accept;
	logic [1:0] used;
	logic [1:0] rem;
	logic [2:0] map_code [4];
	logic [4:0] map_reg [4];
	fetch_decode_pkg::dec_t d;

	assign head = s_reg.parcel[0];

	parcel_order u_order (
		.i_word(i_fetch_word),
		.i_big_endian(s_reg.end_s2),
		.o_first(first_parcel),
		.o_second(second_parcel)
	);

	// ==========================================================
	// short register code maps
	assign map_code[0] = head[9:7];
	assign map_code[1] = head[6:4];
	assign map_code[2] = head[3:1];
	assign map_code[3] = head[9:7];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_map
			short_reg_map u_map (
				.i_code(map_code[g]),
				.i_store_src(g == 3),
				.o_reg(map_reg[g])
			);
		end
	endgenerate

	// ==========================================================
	// decode of the head instruction
	always_comb begin
		d = '0;
		d.valid = 1'b1;
		d.is_long = !short_head;
		if (short_head) begin
			d.instr = {16'h0000, head};
		end else begin
			d.instr = {head, s_reg.parcel[1]};
		end
		if (!short_head) begin
			d.op = fetch_decode_pkg::op_long;
			d.rt = d.instr[25:21];
			d.rs = d.instr[20:16];
			d.rd = d.instr[15:11];
		end else begin
			case (head[15:10])
				fetch_decode_pkg::MAJ_MOVE: begin
					d.rd = head[9:5];
					d.rs = head[4:0];
					if (d.rd == fetch_decode_pkg::REG_ZERO
						&& d.rs == fetch_decode_pkg::REG_ZERO) begin
						d.op = fetch_decode_pkg::op_nop;
					end else begin
						d.op = fetch_decode_pkg::op_move;
						d.wr_en = 1'b1;
					end
				end
				fetch_decode_pkg::MAJ_POOL_ADDI: begin
					d.op = fetch_decode_pkg::op_add_imm;
					d.wr_en = 1'b1;
					if (head[0] == fetch_decode_pkg::MINOR_ADDI_SAME) begin
						d.rd = head[9:5];
						d.rs = head[9:5];
						d.imm = {{28{head[4]}}, head[4:1]};
					end else begin
						d.rd = fetch_decode_pkg::REG_SP;
						d.rs = fetch_decode_pkg::REG_SP;
						d.imm = {{23{head[9]}}, head[9:1]} << fetch_decode_pkg::WORD_SHIFT;
					end
				end
				fetch_decode_pkg::MAJ_POOL_ADDR: begin
					d.op = fetch_decode_pkg::op_add_imm;
					d.wr_en = 1'b1;
					d.rd = map_reg[0];
					if (head[0] == fetch_decode_pkg::MINOR_ADDI_TWO) begin
						d.rs = map_reg[1];
						d.imm = fetch_decode_pkg::two_reg_imm(head[3:1]);
					end else begin
						d.rs = fetch_decode_pkg::REG_SP;
						d.imm = {26'h0000000, head[6:1]} << fetch_decode_pkg::WORD_SHIFT;
					end
				end
				fetch_decode_pkg::MAJ_POOL_ARITH: begin
					d.rs = map_reg[0];
					d.rt = map_reg[1];
					d.rd = map_reg[2];
					d.wr_en = 1'b1;
					d.op = (head[0] == fetch_decode_pkg::MINOR_SUB)
						? fetch_decode_pkg::op_sub : fetch_decode_pkg::op_add;
				end
				fetch_decode_pkg::MAJ_NEGATE: begin
					d.op = fetch_decode_pkg::op_sub;
					d.rs = fetch_decode_pkg::REG_ZERO;
					d.rt = map_reg[1];
					d.rd = map_reg[0];
					d.wr_en = 1'b1;
				end
				fetch_decode_pkg::MAJ_LOAD_SP: begin
					d.op = fetch_decode_pkg::op_load_word;
					d.rd = head[9:5];
					d.rs = fetch_decode_pkg::REG_SP;
					d.imm = {27'h0000000, head[4:0]} << fetch_decode_pkg::WORD_SHIFT;
					d.wr_en = 1'b1;
				end
				fetch_decode_pkg::MAJ_STORE_SP: begin
					d.op = fetch_decode_pkg::op_store_word;
					d.rt = head[9:5];
					d.rs = fetch_decode_pkg::REG_SP;
					d.imm = {27'h0000000, head[4:0]} << fetch_decode_pkg::WORD_SHIFT;
				end
				fetch_decode_pkg::MAJ_BRANCH_ZERO, fetch_decode_pkg::MAJ_BRANCH_NZ: begin
					d.op = (head[15:10] == fetch_decode_pkg::MAJ_BRANCH_ZERO)
						? fetch_decode_pkg::op_branch_zero
						: fetch_decode_pkg::op_branch_nonzero;
					d.rs = map_reg[0];
					d.imm = {{25{head[6]}}, head[6:0]} << fetch_decode_pkg::HALF_SHIFT;
					d.slot = fetch_decode_pkg::slot_any;
				end
				fetch_decode_pkg::MAJ_BRANCH: begin
					d.op = fetch_decode_pkg::op_branch;
					d.imm = {{22{head[9]}}, head[9:0]} << fetch_decode_pkg::HALF_SHIFT;
					d.slot = fetch_decode_pkg::slot_any;
				end
				fetch_decode_pkg::MAJ_STORE_BYTE: begin
					d.op = fetch_decode_pkg::op_store_byte;
					d.rt = map_reg[3];
					d.rs = map_reg[1];
					d.imm = {28'h0000000, head[3:0]};
				end
				fetch_decode_pkg::MAJ_STORE_HALF: begin
					d.op = fetch_decode_pkg::op_store_half;
					d.rt = map_reg[3];
					d.rs = map_reg[1];
					d.imm = {28'h0000000, head[3:0]} << fetch_decode_pkg::HALF_SHIFT;
				end
				fetch_decode_pkg::MAJ_STORE_WORD: begin
					d.op = fetch_decode_pkg::op_store_word;
					d.rt = map_reg[3];
					d.rs = map_reg[1];
					d.imm = {28'h0000000, head[3:0]} << fetch_decode_pkg::WORD_SHIFT;
				end
				fetch_decode_pkg::MAJ_POOL_CTRL: begin
					if (head[9:4] == fetch_decode_pkg::MINOR_BREAK) begin
						d.op = fetch_decode_pkg::op_break;
						d.brk = 1'b1;
						d.code = head[3:0];
					end else if (head[9:4] == fetch_decode_pkg::MINOR_DEBUG) begin
						d.op = fetch_decode_pkg::op_debug_break;
						d.dbg = 1'b1;
						d.code = head[3:0];
					end else begin
						d.rs = head[4:0];
						case (head[9:5])
							fetch_decode_pkg::MINOR_JR: begin
								d.op = fetch_decode_pkg::op_jump_reg;
								d.slot = fetch_decode_pkg::slot_any;
							end
							fetch_decode_pkg::MINOR_JRC: begin
								d.op = fetch_decode_pkg::op_jump_reg;
								d.slot = fetch_decode_pkg::slot_none;
							end
							fetch_decode_pkg::MINOR_JALR, fetch_decode_pkg::MINOR_JALRS: begin
								d.op = fetch_decode_pkg::op_jump_link_reg;
								d.rd = fetch_decode_pkg::REG_RA;
								d.wr_en = 1'b1;
								d.slot = (head[9:5] == fetch_decode_pkg::MINOR_JALR)
									? fetch_decode_pkg::slot_long
									: fetch_decode_pkg::slot_short;
							end
							fetch_decode_pkg::MINOR_RET_ADJ: begin
								d.op = fetch_decode_pkg::op_return_adjust;
								d.rs = fetch_decode_pkg::REG_RA;
								d.rd = fetch_decode_pkg::REG_SP;
								d.wr_en = 1'b1;
								d.imm = {27'h0000000, head[4:0]} << fetch_decode_pkg::WORD_SHIFT;
							end
							default: begin
								d.op = fetch_decode_pkg::op_other;
								d.rs = fetch_decode_pkg::REG_ZERO;
							end
						endcase
					end
				end
				default: d.op = fetch_decode_pkg::op_other;
			endcase
		end
	end

	// ==========================================================
	// parcel buffer and output stage
	always_comb begin
		s_next = s_reg;
		short_head = fetch_decode_pkg::is_short(head[15:10]);
		take = (s_reg.cnt != fetch_decode_pkg::PARCEL_NONE)
			&& (short_head || s_reg.cnt >= fetch_decode_pkg::PARCEL_TWO);
		emit = take && (!s_reg.dec.valid || i_dec_ready);
		accept = s_reg.rdy && i_fetch_valid && !i_flush;
		used = fetch_decode_pkg::PARCEL_NONE;
		if (emit) begin
			used = short_head ? fetch_decode_pkg::PARCEL_ONE : fetch_decode_pkg::PARCEL_TWO;
		end
		rem = s_reg.cnt - used;
		// pin passes two flops before the aligner sees it
		s_next.end_s1 = i_big_endian;
		s_next.end_s2 = s_reg.end_s1;
		if (emit) begin
			s_next.dec = d;
		end else if (i_dec_ready) begin
			s_next.dec.valid = 1'b0;
		end
		// oldest parcel always sits at index zero
		if (used == fetch_decode_pkg::PARCEL_ONE) begin
			s_next.parcel[0] = s_reg.parcel[1];
			s_next.parcel[1] = s_reg.parcel[2];
		end else if (used == fetch_decode_pkg::PARCEL_TWO) begin
			s_next.parcel[0] = s_reg.parcel[2];
		end
		if (accept) begin
			s_next.parcel[rem] = first_parcel;
			s_next.parcel[rem + fetch_decode_pkg::PARCEL_ONE] = second_parcel;
			s_next.cnt = rem + fetch_decode_pkg::PARCEL_TWO;
		end else begin
			s_next.cnt = rem;
		end
		if (i_flush) begin
			s_next.cnt = fetch_decode_pkg::PARCEL_NONE;
			s_next.dec.valid = 1'b0;
		end
		// ready only when a whole word fits behind a leftover parcel
		s_next.rdy = (s_next.cnt <= fetch_decode_pkg::PARCEL_ONE);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			s_reg <= '0;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	assign o_fetch_ready = s_reg.rdy;
	assign o_dec = s_reg.dec;

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	a_big_endian_order: assert property (
		i_ce && accept && s_reg.cnt == fetch_decode_pkg::PARCEL_NONE && s_reg.end_s2
		|=> s_reg.parcel[0] == $past(i_fetch_word[31:16])
			&& s_reg.parcel[1] == $past(i_fetch_word[15:0]))
		else $error("big-endian parcel order wrong");

	a_little_endian_order: assert property (
		i_ce && accept && s_reg.cnt == fetch_decode_pkg::PARCEL_NONE && !s_reg.end_s2
		|=> s_reg.parcel[0] == $past(i_fetch_word[15:0])
			&& s_reg.parcel[1] == $past(i_fetch_word[31:16]))
		else $error("little-endian parcel order wrong");

	a_long_assembly: assert property (
		i_ce && emit && !short_head
		|=> o_dec.valid && o_dec.is_long
			&& o_dec.instr == {$past(s_reg.parcel[0]), $past(s_reg.parcel[1])})
		else $error("long instruction halves misplaced");

	a_length_from_major: assert property (
		o_dec.valid |-> o_dec.is_long == !fetch_decode_pkg::is_short(
			o_dec.is_long ? o_dec.instr[31:26] : o_dec.instr[15:10]))
		else $error("length disagrees with major opcode");

	a_ascending_order: assert property (
		i_ce && emit && short_head && !accept && !i_flush
		|=> s_reg.parcel[0] == $past(s_reg.parcel[1])
			&& s_reg.cnt == $past(s_reg.cnt) - fetch_decode_pkg::PARCEL_ONE)
		else $error("parcels not consumed in order");

	a_sp_offset_scale: assert property (
		o_dec.valid && o_dec.rs == fetch_decode_pkg::REG_SP && !o_dec.is_long
		&& (o_dec.op == fetch_decode_pkg::op_load_word
			|| o_dec.op == fetch_decode_pkg::op_store_word)
		|-> o_dec.imm == {25'h0000000, o_dec.instr[4:0], 2'h0})
		else $error("stack offset not scaled by four");

	a_branch_scale: assert property (
		o_dec.valid && (o_dec.op == fetch_decode_pkg::op_branch_zero
			|| o_dec.op == fetch_decode_pkg::op_branch_nonzero)
		|-> o_dec.imm == {{24{o_dec.instr[6]}}, o_dec.instr[6:0], 1'h0})
		else $error("branch offset not scaled by two");

	a_nop_no_effect: assert property (
		o_dec.valid && !o_dec.is_long && o_dec.instr[15:0] == {fetch_decode_pkg::MAJ_MOVE, 10'h000}
		|-> o_dec.op == fetch_decode_pkg::op_nop && !o_dec.wr_en)
		else $error("no-op has an effect");

	a_move_linear: assert property (
		o_dec.valid && o_dec.op == fetch_decode_pkg::op_move
		|-> o_dec.rd == o_dec.instr[9:5] && o_dec.rs == o_dec.instr[4:0])
		else $error("move registers not linear");

	a_ready_tracks_fill: assert property (
		i_ce |=> o_fetch_ready == (s_reg.cnt <= fetch_decode_pkg::PARCEL_ONE))
		else $error("ready disagrees with buffer fill");

	c_straddle: cover property (accept && s_reg.cnt == fetch_decode_pkg::PARCEL_ONE);
	c_long_emit: cover property (emit && !short_head);
	c_nop_out: cover property (o_dec.valid && o_dec.op == fetch_decode_pkg::op_nop);
	c_break_out: cover property (o_dec.valid && o_dec.brk);
endmodule

// [sim/fetch_source_model.sv]
// fetch-path model offering aligned instruction words to the decoder
`timescale 1ns/1ps
module fetch_source_model (
	input wire logic i_ref_clk, // core clock
	input wire logic i_ready, // decoder can take a word
	output logic o_valid, // word offered
	output logic [31:0] o_word // offered aligned word
);
	logic [31:0] words_q[$];
	logic taken_reg = 1'b0;

	initial begin
		o_valid = 1'b0;
		o_word = 32'h00000000;
	end

	task automatic push(input logic [31:0] w);
		words_q.push_back(w);
	endtask

	// ==========================================================
	// handshake
	always @(posedge i_ref_clk) begin
		taken_reg = o_valid && i_ready;
	end

	// words go out strictly by rising address
	// an idle bus toggles, so a stale word can never pass for a fresh one
	always @(negedge i_ref_clk) begin
		if (taken_reg) begin
			void'(words_q.pop_front());
		end
		taken_reg = 1'b0;
		if (words_q.size() > 0) begin
			o_valid = 1'b1;
			o_word = words_q[0];
		end else begin
			o_valid = 1'b0;
			o_word = ~o_word;
		end
	end
endmodule

// [sim/tb_top.sv]
// self-checking bench of the short-instruction fetch decoder
`timescale 1ns/1ps
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_big_endian = 1'b0;
	logic i_dec_ready = 1'b1;
	logic i_ce = 1'b1;
	logic i_flush = 1'b0;
	logic fetch_valid;
	logic [31:0] fetch_word;
	logic o_fetch_ready;
	fetch_decode_pkg::dec_t o_dec;
	fetch_decode_pkg::dec_t d;
	fetch_decode_pkg::dec_t got_q[$];
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;

	always #20 i_ref_clk = ~i_ref_clk;

	short_fetch_decoder dut (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_big_endian(i_big_endian),
		.i_flush(i_flush),
		.i_fetch_valid(fetch_valid),
		.i_fetch_word(fetch_word),
		.o_fetch_ready(o_fetch_ready),
		.i_dec_ready(i_dec_ready),
		.o_dec(o_dec)
	);

	fetch_source_model src (
		.i_ref_clk(i_ref_clk),
		// a word only counts as taken on an enabled, unflushed edge
		.i_ready(o_fetch_ready && i_ce && !i_flush),
		.o_valid(fetch_valid),
		.o_word(fetch_word)
	);

	// ==========================================================
	// collector and watchdog
	always @(posedge i_ref_clk) begin
		if (o_dec.valid === 1'b1 && i_dec_ready === 1'b1) begin
			got_q.push_back(o_dec);
		end
	end

	always @(negedge i_ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	// ==========================================================
	// helpers
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// first parcel at the lower address, placed by the current byte order
	function automatic logic [31:0] pk(input logic [15:0] a, input logic [15:0] b);
		pk = i_big_endian ? {a, b} : {b, a};
	endfunction

	task automatic collect(input int n);
		int k;
		k = 0;
		while (got_q.size() < n && k < 200) begin
			@(negedge i_ref_clk);
			k++;
		end
		chk(32'(got_q.size()), 32'(n));
	endtask

	// one short parcel followed by a no-op, first result left in d
	task automatic one(input logic [15:0] p, input fetch_decode_pkg::op_t op);
		got_q.delete();
		src.push(pk(p, {fetch_decode_pkg::MAJ_MOVE, 10'h000}));
		collect(2);
		d = got_q[0];
		chk(32'(d.op), 32'(op));
		chk(d.instr, {16'h0000, p});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_little();
		logic [15:0] a;
		a = {fetch_decode_pkg::MAJ_MOVE, 5'h1F, 5'h01};
		got_q.delete();
		i_dec_ready = 1'b0;
		src.push(pk(a, {fetch_decode_pkg::MAJ_MOVE, 10'h000}));
		src.push(pk(16'h0021, 16'h3840));
		repeat (8) @(negedge i_ref_clk);
		chk(o_dec.instr, {16'h0000, a});
		i_dec_ready = 1'b1;
		collect(3);
		chk(32'(got_q[0].rd), 32'h0000001F);
		chk(32'(got_q[0].rs), 32'h00000001);
		chk(32'(got_q[1].op), 32'(fetch_decode_pkg::op_nop));
		chk(32'(got_q[1].wr_en), 32'h00000000);
		chk(got_q[2].instr, 32'h00213840);
		$display("test little-endian order done");
	endtask

	task automatic t_table();
		logic [15:0] p;
		p = {fetch_decode_pkg::MAJ_LOAD_SP, 5'h09, 5'h1F};
		one(p, fetch_decode_pkg::op_load_word);
		chk(d.imm, 32'h0000007C);
		chk(32'(d.rd), 32'h00000009);
		p = {fetch_decode_pkg::MAJ_BRANCH, 10'h3FF};
		one(p, fetch_decode_pkg::op_branch);
		chk(d.imm, 32'hFFFFFFFE);
		p = {fetch_decode_pkg::MAJ_BRANCH_ZERO, 3'h0, 7'h40};
		one(p, fetch_decode_pkg::op_branch_zero);
		chk(d.imm, 32'hFFFFFF80);
		p = {fetch_decode_pkg::MAJ_BRANCH_NZ, 3'h2, 7'h3F};
		one(p, fetch_decode_pkg::op_branch_nonzero);
		chk(d.imm, 32'h0000007E);
		p = {fetch_decode_pkg::MAJ_POOL_ADDI, 5'h1E, 4'h8, fetch_decode_pkg::MINOR_ADDI_SAME};
		one(p, fetch_decode_pkg::op_add_imm);
		chk(d.imm, 32'hFFFFFFF8);
		chk(32'(d.rd), 32'h0000001E);
		p = {fetch_decode_pkg::MAJ_POOL_ADDI, 9'h005, 1'b1};
		one(p, fetch_decode_pkg::op_add_imm);
		chk(d.imm, 32'h00000014);
		chk(32'(d.rd), 32'(fetch_decode_pkg::REG_SP));
		p = {fetch_decode_pkg::MAJ_POOL_ADDR, 3'h0, 3'h7, 3'h0, fetch_decode_pkg::MINOR_ADDI_TWO};
		one(p, fetch_decode_pkg::op_add_imm);
		chk(d.imm, 32'hFFFFFFFF);
		chk(32'(d.rd), 32'h00000010);
		chk(32'(d.rs), 32'h00000007);
		p = {fetch_decode_pkg::MAJ_POOL_ADDR, 3'h1, 6'h3F, 1'b1};
		one(p, fetch_decode_pkg::op_add_imm);
		chk(d.imm, 32'h000000FC);
		chk(32'(d.rd), 32'h00000011);
		p = {fetch_decode_pkg::MAJ_NEGATE, 3'h2, 3'h3, 4'h0};
		one(p, fetch_decode_pkg::op_sub);
		chk({d.rd, d.rs, d.rt}, {17'h00000, 5'h02, 5'h00, 5'h03});
		p = {fetch_decode_pkg::MAJ_POOL_ARITH, 3'h0, 3'h1, 3'h7, fetch_decode_pkg::MINOR_SUB};
		one(p, fetch_decode_pkg::op_sub);
		chk({d.rs, d.rt, d.rd}, {17'h00000, 5'h10, 5'h11, 5'h07});
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_BREAK, 4'hA};
		one(p, fetch_decode_pkg::op_break);
		chk({d.brk, d.code}, {27'h0000000, 1'b1, 4'hA});
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_DEBUG, 4'h5};
		one(p, fetch_decode_pkg::op_debug_break);
		chk({d.dbg, d.code}, {27'h0000000, 1'b1, 4'h5});
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_JALR, 5'h1F};
		one(p, fetch_decode_pkg::op_jump_link_reg);
		chk(32'(d.slot), 32'(fetch_decode_pkg::slot_long));
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_JALRS, 5'h03};
		one(p, fetch_decode_pkg::op_jump_link_reg);
		chk(32'(d.slot), 32'(fetch_decode_pkg::slot_short));
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_JRC, 5'h1F};
		one(p, fetch_decode_pkg::op_jump_reg);
		chk(32'(d.slot), 32'(fetch_decode_pkg::slot_none));
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_JR, 5'h1F};
		one(p, fetch_decode_pkg::op_jump_reg);
		chk(32'(d.slot), 32'(fetch_decode_pkg::slot_any));
		p = {fetch_decode_pkg::MAJ_POOL_CTRL, fetch_decode_pkg::MINOR_RET_ADJ, 5'h1F};
		one(p, fetch_decode_pkg::op_return_adjust);
		chk({d.imm[26:0], d.rs}, {27'h000007C, 5'h1F});
		p = {fetch_decode_pkg::MAJ_STORE_WORD, 3'h0, 3'h1, 4'h3};
		one(p, fetch_decode_pkg::op_store_word);
		chk({d.rt, d.rs, d.imm[7:0]}, {14'h0000, 5'h00, 5'h11, 8'h0C});
		p = {fetch_decode_pkg::MAJ_STORE_BYTE, 3'h2, 3'h0, 4'hF};
		one(p, fetch_decode_pkg::op_store_byte);
		chk({d.rt, d.rs, d.imm[7:0]}, {14'h0000, 5'h02, 5'h10, 8'h0F});
		p = {fetch_decode_pkg::MAJ_STORE_SP, 5'h04, 5'h01};
		one(p, fetch_decode_pkg::op_store_word);
		chk({d.rt, d.rs, d.imm[7:0]}, {14'h0000, 5'h04, 5'h1D, 8'h04});
		$display("test short field decode done");
	endtask

	task automatic t_big();
		i_big_endian = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		got_q.delete();
		src.push(pk({fetch_decode_pkg::MAJ_MOVE, 5'h02, 5'h03}, 16'h0021));
		src.push(pk(16'h3840, {fetch_decode_pkg::MAJ_MOVE, 5'h04, 5'h05}));
		collect(3);
		chk(32'(got_q[0].rd), 32'h00000002);
		chk(got_q[1].instr, 32'h00213840);
		chk(32'(got_q[1].is_long), 32'h00000001);
		chk({got_q[1].rt, got_q[1].rd}, {22'h000000, 5'h01, 5'h07});
		chk(32'(got_q[2].rd), 32'h00000004);
		$display("test big-endian straddle done");
	endtask

	// clock enable freezes everything, flush drops buffer and output
	task automatic t_hold();
		got_q.delete();
		i_dec_ready = 1'b0;
		i_ce = 1'b0;
		src.push(pk({fetch_decode_pkg::MAJ_MOVE, 5'h06, 5'h07},
			{fetch_decode_pkg::MAJ_MOVE, 5'h08, 5'h09}));
		repeat (4) @(negedge i_ref_clk);
		chk(32'({o_fetch_ready, o_dec.valid}), 32'h00000002);
		i_ce = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		chk(o_dec.instr, {16'h0000, fetch_decode_pkg::MAJ_MOVE, 5'h06, 5'h07});
		i_flush = 1'b1;
		@(negedge i_ref_clk);
		i_flush = 1'b0;
		chk(32'({o_fetch_ready, o_dec.valid}), 32'h00000002);
		i_dec_ready = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		chk(32'(got_q.size()), 32'h00000000);
		$display("test hold and flush done");
	endtask

	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_rstn = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		t_little();
		t_table();
		t_big();
		t_hold();
		stop_test();
	end
endmodule
